// [core/pin_irq_pkg.sv]
package pin_irq_pkg;

  // ****************************************************************
  // register map
  // ****************************************************************
  localparam logic [7:0] INPUT_PIN_FUNCTION_CONFIG = 8'h2b;
  localparam logic [7:0] INPUT_PIN_LEVEL_READBACK  = 8'h2f;
  localparam logic [7:0] INTERRUPT_OUTPUT_CONFIG   = 8'h32;
  localparam logic [7:0] IRQ_MASK_BANK             = 8'h33;
  localparam logic [7:0] IRQ_LATCHED_FLAGS         = 8'h36;

  // ****************************************************************
  // reset values and writable bits
  // ****************************************************************
  localparam logic [7:0] INPUT_CFG_RESET = 8'h00;
  localparam logic [7:0] IRQ_CFG_RESET   = 8'h00;
  localparam logic [7:0] MASK_RESET      = 8'hff;
  localparam logic [7:0] LATCH_RESET     = 8'h00;
  localparam logic [7:0] INPUT_CFG_WMASK = 8'h77;
  localparam logic [7:0] IRQ_CFG_WMASK   = 8'he4;
  localparam logic [7:0] LATCH_SOURCES   = 8'hf8;

  // ****************************************************************
  // field positions
  // ****************************************************************
  localparam int FIRST_FN_LSB   = 4;
  localparam int SECOND_FN_LSB  = 0;
  localparam int FIRST_LVL_BIT  = 7;
  localparam int SECOND_LVL_BIT = 6;
  localparam int POLARITY_BIT   = 7;
  localparam int EVENT_LSB      = 5;
  localparam int FILTER_BIT     = 2;

  // ****************************************************************
  // timing
  // ****************************************************************
  localparam int unsigned CLOCK_MHZ       = 250;
  localparam int unsigned IRQ_PULSE_US    = 2000;
  localparam int unsigned IRQ_PERIOD_US   = 4000;
  localparam int unsigned IRQ_PULSE_CYC   = IRQ_PULSE_US * CLOCK_MHZ;
  localparam int unsigned IRQ_PERIOD_CYC  = IRQ_PERIOD_US * CLOCK_MHZ;
  localparam int          COUNT_W         = 20;

  // ****************************************************************
  // types
  // ****************************************************************
  typedef enum logic [2:0] {
    fn_disabled,
    fn_general_input,
    fn_master_clock,
    fn_serial_audio_in,
    fn_pdm_data_pair_a,
    fn_pdm_data_pair_b,
    fn_reserved,
    fn_adc_power_down
  } pin_function_t;

  typedef enum logic [1:0] {
    ev_level,
    ev_reserved,
    ev_repeating,
    ev_single
  } irq_event_mode_t;

  typedef struct packed {
    logic general_input;
    logic master_clock;
    logic serial_audio_in;
    logic pdm_data_pair_a;
    logic pdm_data_pair_b;
    logic adc_power_down;
  } pin_route_t;

  typedef struct packed {
    logic [7:0] addr;
    logic       wr;
    logic       rd;
    logic [7:0] wdata;
  } reg_req_t;

  typedef struct packed {
    logic [7:0]         input_cfg;
    logic [7:0]         irq_cfg;
    logic [7:0]         mask;
    logic [7:0]         latch;
    logic [1:0]         sync_a;
    logic [1:0]         sync_b;
    logic [7:0]         rdata;
    logic [COUNT_W-1:0] count;
    logic               irq_active;
    logic               irq_out;
  } state_t;

endpackage

// [core/input_pin_and_irq_config.sv]
// How it works
// [R1] bits 6:4 pick first pin function; 0 off, 1 general input
// [R2] code 2 routes master clock, code 3 serial audio data in
// [R3] code 4 PDM data for channels 1-2, code 5 for channels 3-4
// [R4] code 7 turns the pin into an all-ADC power-down control
// [R5] software never writes reserved code 6 to a function field
// [R6] bits 2:0 give bias-shared pin the same function codes
// [R7] reserved bits 7 and 3 written zero; they read zero
// [R8] level bit 7 shows first pin while it is a general input
// [R9] level bit 6 shows bias-shared pin likewise; bits 5:0 zero
// [R10] interrupt config bit 7: 0 active low, 1 active high output
// [R11] event code 0: asserted while any unmasked latched flag stands
// [R12] event code 2: 2 ms on in every 4 ms while flags stand
// [R13] event code 3: a 2 ms pulse per unmasked event; an event during a pulse restarts it
// [R14] bit 2 set hides masked flags from the latched flag readback
// [R15] mask bits reset to 1; writing 0 lets a source interrupt
// [R16] latched flag sets on its event, clears once it is read
// [R17] pin levels pass two flip-flops before anything reads them
module input_pin_and_irq_config #(
  parameter int unsigned PULSE_CYCLES  = pin_irq_pkg::IRQ_PULSE_CYC,
  parameter int unsigned PERIOD_CYCLES = pin_irq_pkg::IRQ_PERIOD_CYC
) (
  // clock and reset
  input  wire logic                   mclk,
  input  wire logic                   arst_n,
  // register port
  input  wire pin_irq_pkg::reg_req_t  reg_req,
  output logic [7:0]                  reg_rdata,
  // pins
  input  wire logic                   analog_input_shared_pin,
  input  wire logic                   mic_bias_shared_pin,
  output logic                        irq_pin,
  // function routing
  output pin_irq_pkg::pin_route_t     first_route,
  output pin_irq_pkg::pin_route_t     second_route,
  output logic                        adc_power_down,
  output logic [1:0]                  pin_level,
  // interrupt sources, one-cycle pulses
  input  wire logic [7:0]             irq_event
);

  // ****************************************************************
  // state
  // ****************************************************************
  pin_irq_pkg::state_t state;
  pin_irq_pkg::state_t next_state;

  localparam logic [pin_irq_pkg::COUNT_W-1:0] PULSE_N =
    pin_irq_pkg::COUNT_W'(PULSE_CYCLES);
  localparam logic [pin_irq_pkg::COUNT_W-1:0] PERIOD_N =
    pin_irq_pkg::COUNT_W'(PERIOD_CYCLES);
  localparam logic [pin_irq_pkg::COUNT_W-1:0] ONE =
    pin_irq_pkg::COUNT_W'(1);

  pin_irq_pkg::pin_function_t first_input_function;
  pin_irq_pkg::pin_function_t second_input_function;
  pin_irq_pkg::irq_event_mode_t event_mode;
  logic [1:0] level;
  logic       irq_polarity;
  logic       latch_readback_filter;
  logic [7:0] visible_latch;
  logic [7:0] new_events;
  logic       pending;
  logic       fresh_event;

  // ****************************************************************
  // decode
  // ****************************************************************
  assign first_input_function  = pin_irq_pkg::pin_function_t'(
    state.input_cfg[pin_irq_pkg::FIRST_FN_LSB +: 3]);  // [R1]
  assign second_input_function = pin_irq_pkg::pin_function_t'(
    state.input_cfg[pin_irq_pkg::SECOND_FN_LSB +: 3]); // [R6]
  assign event_mode            = pin_irq_pkg::irq_event_mode_t'(
    state.irq_cfg[pin_irq_pkg::EVENT_LSB +: 2]);
  assign irq_polarity          = state.irq_cfg[pin_irq_pkg::POLARITY_BIT];
  assign latch_readback_filter = state.irq_cfg[pin_irq_pkg::FILTER_BIT];
  // second flop only; the first one is left to settle
  assign level                 = {state.sync_a[1], state.sync_b[1]}; // [R17]
  assign new_events            = irq_event & pin_irq_pkg::LATCH_SOURCES;
  assign pending               = |(state.latch & ~state.mask);
  assign fresh_event           = |(new_events & ~state.mask); // [R15]
  assign visible_latch         = latch_readback_filter ?
                                 (state.latch & ~state.mask) : state.latch; // [R14]

  function automatic pin_irq_pkg::pin_route_t route(
    input pin_irq_pkg::pin_function_t fn,
    input logic                       lvl
  );
    pin_irq_pkg::pin_route_t r;
    r.general_input   = (fn == pin_irq_pkg::fn_general_input);   // [R1]
    r.master_clock    = (fn == pin_irq_pkg::fn_master_clock);    // [R2]
    r.serial_audio_in = (fn == pin_irq_pkg::fn_serial_audio_in); // [R2]
    r.pdm_data_pair_a = (fn == pin_irq_pkg::fn_pdm_data_pair_a); // [R3]
    r.pdm_data_pair_b = (fn == pin_irq_pkg::fn_pdm_data_pair_b); // [R3]
    // code 6 is never programmed, so it simply routes nowhere
    r.adc_power_down  = (fn == pin_irq_pkg::fn_adc_power_down) && lvl; // [R4] [R5]
    return r;
  endfunction

  assign first_route    = route(first_input_function, level[1]);
  assign second_route   = route(second_input_function, level[0]); // [R6]
  assign adc_power_down = first_route.adc_power_down | second_route.adc_power_down; // [R4]
  assign pin_level      = level;
  assign reg_rdata      = state.rdata;
  assign irq_pin        = state.irq_out;

  // ****************************************************************
  // next state
  // ****************************************************************
  always_comb begin
    next_state = state;

    next_state.sync_a = {state.sync_a[0], analog_input_shared_pin}; // [R17]
    next_state.sync_b = {state.sync_b[0], mic_bias_shared_pin};     // [R17]

    // read data and read side effects
    if (reg_req.rd) begin
      unique case (reg_req.addr)
        pin_irq_pkg::INPUT_PIN_FUNCTION_CONFIG: next_state.rdata = state.input_cfg; // [R7]
        pin_irq_pkg::INPUT_PIN_LEVEL_READBACK: begin
          next_state.rdata = 8'h00; // [R9]
          next_state.rdata[pin_irq_pkg::FIRST_LVL_BIT] =
            level[1] && (first_input_function == pin_irq_pkg::fn_general_input); // [R8]
          next_state.rdata[pin_irq_pkg::SECOND_LVL_BIT] =
            level[0] && (second_input_function == pin_irq_pkg::fn_general_input); // [R9]
        end
        pin_irq_pkg::INTERRUPT_OUTPUT_CONFIG: next_state.rdata = state.irq_cfg;
        pin_irq_pkg::IRQ_MASK_BANK:           next_state.rdata = state.mask;
        pin_irq_pkg::IRQ_LATCHED_FLAGS: begin
          next_state.rdata = visible_latch;
          // only what software actually saw is cleared
          next_state.latch = state.latch & ~visible_latch; // [R16]
        end
        default:                              next_state.rdata = 8'h00;
      endcase
    end

    // an event in the clearing cycle survives
    next_state.latch = next_state.latch | new_events; // [R16]

    if (reg_req.wr) begin
      unique case (reg_req.addr)
        pin_irq_pkg::INPUT_PIN_FUNCTION_CONFIG:
          next_state.input_cfg = reg_req.wdata & pin_irq_pkg::INPUT_CFG_WMASK; // [R7]
        pin_irq_pkg::INTERRUPT_OUTPUT_CONFIG:
          next_state.irq_cfg = reg_req.wdata & pin_irq_pkg::IRQ_CFG_WMASK;
        pin_irq_pkg::IRQ_MASK_BANK:
          next_state.mask = reg_req.wdata; // [R15]
        default: ;
      endcase
    end

    // interrupt shaping
    unique case (event_mode)
      pin_irq_pkg::ev_repeating: begin
        if (!pending) begin
          next_state.count = '0;
        end else if (state.count >= PERIOD_N - ONE) begin
          next_state.count = '0;
        end else begin
          next_state.count = state.count + ONE;
        end
        next_state.irq_active = pending && (state.count < PULSE_N); // [R12]
      end
      pin_irq_pkg::ev_single: begin
        // a new event restarts the pulse rather than stretching a queue
        if (fresh_event) begin
          next_state.count = ONE;
        end else if (state.count != '0 && state.count < PULSE_N) begin
          next_state.count = state.count + ONE;
        end else begin
          next_state.count = '0;
        end
        next_state.irq_active = (next_state.count != '0); // [R13]
      end
      default: begin
        // reserved code 1 behaves as level so the pin stays sane
        next_state.count      = '0;
        next_state.irq_active = pending; // [R11]
      end
    endcase

    next_state.irq_out = irq_polarity ? next_state.irq_active
                                      : ~next_state.irq_active; // [R10]
  end

  // ****************************************************************
  // registers
  // ****************************************************************
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      state            <= '0;
      state.input_cfg  <= pin_irq_pkg::INPUT_CFG_RESET;
      state.irq_cfg    <= pin_irq_pkg::IRQ_CFG_RESET;
      state.mask       <= pin_irq_pkg::MASK_RESET; // [R15]
      state.latch      <= pin_irq_pkg::LATCH_RESET;
      state.irq_out    <= 1'b1;
    end else begin
      state <= next_state;
    end
  end

endmodule

// [sim/pin_irq_sva.sv]
module pin_irq_sva #(
  parameter int unsigned PULSE_CYCLES  = 8,
  parameter int unsigned PERIOD_CYCLES = 16
) (
  // clock and reset
  input wire logic                    mclk,
  input wire logic                    arst_n,
  // register port and pins
  input wire pin_irq_pkg::reg_req_t   reg_req,
  input wire logic [7:0]              reg_rdata,
  input wire logic                    analog_input_shared_pin,
  input wire logic                    mic_bias_shared_pin,
  input wire logic                    irq_pin,
  // routing and sources
  input wire pin_irq_pkg::pin_route_t first_route,
  input wire pin_irq_pkg::pin_route_t second_route,
  input wire logic                    adc_power_down,
  input wire logic [1:0]              pin_level,
  input wire logic [7:0]              irq_event
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [7:0] sh_in;
  logic [7:0] sh_irq;
  logic [7:0] sh_mask;
  logic [1:0] up;
  logic [7:0] run;
  wire        act = irq_pin == sh_irq[7];
  function automatic pin_irq_pkg::pin_route_t dec(input logic [2:0] f, input logic l);
    dec = 6'h00;
    // power-down only while the synchronised pin is high
    if (f == 3'h7) dec = {5'h00, l};
    else if (f != 3'h0 && f != 3'h6) dec = 6'h01 << (3'h6 - f);
  endfunction
  // ****************
  // shadow of writes
  // ****************
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      sh_in <= 8'h00;
      sh_irq <= 8'h00;
      sh_mask <= 8'hff;
      up <= 2'h0;
      run <= 8'h00;
    end else begin
      if (reg_req.wr && reg_req.addr == 8'h2b) sh_in <= reg_req.wdata & 8'h77;
      if (reg_req.wr && reg_req.addr == 8'h32) sh_irq <= reg_req.wdata & 8'he4;
      if (reg_req.wr && reg_req.addr == 8'h33) sh_mask <= reg_req.wdata;
      if (up != 2'h3) up <= up + 2'h1;
      run <= act ? run + 8'h01 : 8'h00;
    end
  end
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!arst_n);
  route_first_a: assert property (first_route == dec(sh_in[6:4], pin_level[1]))
    else $error("first route wrong");
  route_second_a: assert property (second_route == dec(sh_in[2:0], pin_level[0]))
    else $error("second route wrong");
  power_down_a: assert property (adc_power_down ==
    (sh_in[6:4] == 3'h7 && pin_level[1] || sh_in[2:0] == 3'h7 && pin_level[0]))
    else $error("power down wrong");
  level_sync_a: assert property (up == 2'h3 |-> pin_level ==
    {$past(analog_input_shared_pin, 2), $past(mic_bias_shared_pin, 2)})
    else $error("pin level not two stages");
  level_irq_a: assert property (sh_irq[6] == 1'b0 &&
    (irq_event & ~sh_mask & 8'hf8) != 8'h00 |-> ##3 irq_pin == sh_irq[7])
    else $error("level irq late");
  level_read_a: assert property (reg_req.rd && reg_req.addr == 8'h2f |=>
    reg_rdata == {$past(pin_level[1]) && $past(sh_in[6:4]) == 3'h1,
                  $past(pin_level[0]) && $past(sh_in[2:0]) == 3'h1, 6'h00})
    else $error("level readback wrong");
  cfg_read_a: assert property (reg_req.rd && reg_req.addr == 8'h2b |=>
    reg_rdata == $past(sh_in))
    else $error("input config readback wrong");
  single_len_a: assert property ($fell(act) && sh_irq[6:5] == 2'h3 &&
    $stable(sh_irq) |-> run == PULSE_CYCLES)
    else $error("single pulse length wrong");
  cover property (act && sh_irq[6:5] == 2'h3);
  cover property (act && sh_irq[6:5] == 2'h2);
  cover property (adc_power_down);
endmodule
bind input_pin_and_irq_config pin_irq_sva #(
  .PULSE_CYCLES(PULSE_CYCLES), .PERIOD_CYCLES(PERIOD_CYCLES)) u_sva (
  .mclk(mclk), .arst_n(arst_n), .reg_req(reg_req), .reg_rdata(reg_rdata),
  .analog_input_shared_pin(analog_input_shared_pin), .irq_pin(irq_pin),
  .mic_bias_shared_pin(mic_bias_shared_pin), .first_route(first_route),
  .second_route(second_route), .adc_power_down(adc_power_down),
  .pin_level(pin_level), .irq_event(irq_event));

// [sim/irq_host.sv]
module irq_host (
  // clock and reset
  input wire logic   mclk,
  input wire logic   arst_n,
  // watched pin
  input wire logic   irq_pin,
  input wire logic   pol,
  // measured pulse and rise spacing
  output logic [15:0] len,
  output logic [15:0] gap
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [15:0] hi;
  logic [15:0] since;
  logic        prev;
  wire         act = irq_pin == pol;
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      len <= 16'h0000;
      gap <= 16'h0000;
      hi <= 16'h0000;
      since <= 16'h0000;
      prev <= 1'b0;
    end else begin
      prev <= act;
      hi <= act ? hi + 16'h0001 : 16'h0000;
      since <= (act && !prev) ? 16'h0001 : since + 16'h0001;
      if (prev && !act) len <= hi;
      if (act && !prev) gap <= since;
    end
  end
endmodule

// [sim/tb_top.sv]
module tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int unsigned PULSE  = 8;
  localparam int unsigned PERIOD = 16;
  logic                    mclk;
  logic                    arst_n;
  pin_irq_pkg::reg_req_t   req;
  logic [7:0]              rdata;
  logic                    pin_a;
  logic                    pin_b;
  logic                    irq_pin;
  pin_irq_pkg::pin_route_t route_a;
  pin_irq_pkg::pin_route_t route_b;
  logic                    pwr_dn;
  logic [1:0]              lvl;
  logic [7:0]              irq_event;
  logic                    pol;
  logic [15:0]             len;
  logic [15:0]             gap;
  int                      error_cnt = 0;
  int                      comparisons = 0;
  int                      cyc = 0;
  input_pin_and_irq_config #(.PULSE_CYCLES(PULSE), .PERIOD_CYCLES(PERIOD)) u_dut (
    .mclk(mclk), .arst_n(arst_n), .reg_req(req), .reg_rdata(rdata),
    .analog_input_shared_pin(pin_a), .mic_bias_shared_pin(pin_b), .irq_pin(irq_pin),
    .first_route(route_a), .second_route(route_b), .adc_power_down(pwr_dn),
    .pin_level(lvl), .irq_event(irq_event));
  irq_host u_host (.mclk(mclk), .arst_n(arst_n), .irq_pin(irq_pin), .pol(pol),
    .len(len), .gap(gap));
  initial begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      error_cnt++;
      $display("Error at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge mclk);
    req.addr <= a;
    req.wdata <= v;
    req.wr <= 1'b1;
    @(posedge mclk);
    req.wr <= 1'b0;
  endtask
  task automatic rc(input logic [7:0] a, input logic [7:0] exp);
    @(posedge mclk);
    req.addr <= a;
    req.rd <= 1'b1;
    @(posedge mclk);
    req.rd <= 1'b0;
    #1 chk(rdata, exp);
  endtask
  task automatic ev(input logic [7:0] b);
    @(posedge mclk);
    irq_event <= b;
    @(posedge mclk);
    irq_event <= 8'h00;
  endtask
  function automatic logic [7:0] er(input logic [2:0] f);
    er = 8'h00;
    // first struct member is the top bit: code 1 at bit 5, code 7 at bit 0
    if (f == 3'h7) er = 8'h01;
    else if (f != 3'h0 && f != 3'h6) er = 8'h01 << (3'h6 - f);
  endfunction
  task automatic give_verdict();
    $display("mismatches %0d, comparisons %0d", error_cnt, comparisons);
    if (error_cnt == 0 && comparisons > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  // long stall counts as a mismatch
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      error_cnt++;
      give_verdict();
    end
  end
  initial begin
    arst_n = 1'b0;
    req = '0;
    pin_a = 1'b0;
    pin_b = 1'b0;
    irq_event = 8'h00;
    pol = 1'b0;
    repeat (4) @(posedge mclk);
    arst_n <= 1'b1;
    rc(8'h2b, 8'h00);
    rc(8'h2f, 8'h00);
    rc(8'h32, 8'h00);
    rc(8'h33, 8'hff);
    rc(8'h36, 8'h00);
    chk({7'h00, irq_pin}, 8'h01);
    wr(8'h2b, 8'hff);
    rc(8'h2b, 8'h77);
    wr(8'h2f, 8'hff);
    rc(8'h2f, 8'h00);
    rc(8'h40, 8'h00);
    $display("test reset and access done");
    pin_a <= 1'b1;
    pin_b <= 1'b1;
    for (int f = 0; f < 8; f++) begin
      if (f != 6) begin
        wr(8'h2b, {1'b0, 3'(f), 1'b0, 3'(f)});
        #1 chk({2'h0, route_a}, er(3'(f)));
        chk({2'h0, route_b}, er(3'(f)));
        chk({7'h00, pwr_dn}, {7'h00, f == 7});
      end
    end
    $display("test routing done");
    wr(8'h2b, 8'h11);
    pin_b <= 1'b0;
    repeat (3) @(posedge mclk);
    rc(8'h2f, 8'h80);
    pin_a <= 1'b0;
    pin_b <= 1'b1;
    repeat (3) @(posedge mclk);
    rc(8'h2f, 8'h40);
    $display("test levels done");
    wr(8'h33, 8'h7f);
    ev(8'h80);
    repeat (3) @(posedge mclk);
    #1 chk({7'h00, irq_pin}, 8'h00);
    rc(8'h36, 8'h80);
    repeat (2) @(posedge mclk);
    #1 chk({7'h00, irq_pin}, 8'h01);
    rc(8'h36, 8'h00);
    wr(8'h32, 8'h84);
    pol <= 1'b1;
    ev(8'h08);
    repeat (3) @(posedge mclk);
    #1 chk({7'h00, irq_pin}, 8'h00);
    rc(8'h36, 8'h00);
    wr(8'h32, 8'h80);
    rc(8'h36, 8'h08);
    rc(8'h36, 8'h00);
    $display("test level mode done");
    wr(8'h32, 8'h00);
    pol <= 1'b0;
    wr(8'h32, 8'h60);
    ev(8'h80);
    repeat (PULSE + 4) @(posedge mclk);
    #1 chk(len[7:0], 8'(PULSE));
    rc(8'h36, 8'h80);
    wr(8'h32, 8'h40);
    ev(8'h80);
    repeat (3 * PERIOD) @(posedge mclk);
    #1 chk(gap[7:0], 8'(PERIOD));
    chk(len[7:0], 8'(PULSE));
    rc(8'h36, 8'h80);
    repeat (PERIOD) @(posedge mclk);
    #1 chk({7'h00, irq_pin}, 8'h01);
    $display("test pulse modes done");
    give_verdict();
  end
endmodule
